// *** src/ssr_pkg.sv ***
// constants and types shared by the status summary and service request block
package ssr_pkg;

  // summary byte bit positions
  localparam int SUM_BUSY_BIT = 0;
  localparam int SUM_ERR_BIT  = 2;
  localparam int SUM_QUES_BIT = 3;
  localparam int SUM_MAV_BIT  = 4;
  localparam int SUM_ESB_BIT  = 5;
  localparam int SUM_RQS_BIT  = 6;
  localparam int SUM_OPER_BIT = 7;

  // standard-event layout: power-on 7, command 5, execution 4,
  // device dependent 3, query 2, operation complete 0; bits 6 and 1 fixed zero
  localparam logic [7:0] STD_VALID_MASK = 8'hBD;
  localparam logic [7:0] STD_PON_EVENT  = 8'h80;

  // service-request enable never holds the request bit itself
  localparam logic [7:0] SRE_VALID_MASK = 8'hBF;

  // values after reset
  localparam logic [7:0] STD_EN_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET    = 8'h00;
  localparam logic [7:0] SUM_RESET    = 8'h00;
  localparam logic [7:0] RD_RESET  = 8'h00;

  // host commands and queries
  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_CLS   = 4'h1,
    CMD_SUM_Q    = 4'h2,
    CMD_STD_EN_W = 4'h3,
    CMD_STD_EN_Q = 4'h4,
    CMD_ESR_Q = 4'h5,
    CMD_SRE_W = 4'h6,
    CMD_SRE_Q = 4'h7,
    CMD_QES_Q = 4'h8,
    CMD_OES_Q = 4'h9
  } ssr_cmd_t;

  // state of the top module
  typedef struct packed {
    logic [7:0] std_en;
    logic [7:0] sre;
    logic       pon_pend;
    logic [7:0] sum;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       err_clr;
    logic       out_clr;
  } ssr_main_st_t;

  // state of the service request latch
  typedef struct packed {
    logic rqs;
  } ssr_srq_st_t;

endpackage : ssr_pkg

// *** src/ssr_event_group.sv ***
// latched event register of one status group with enable mask and summary
`timescale 1ns/10ps
`default_nettype none

module ssr_event_group #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // event sources and control
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] enable_i,
  input  wire logic         clear_i,
  // results
  output logic      [W-1:0] event_o,
  output logic              summary_o,
  output logic              rise_o
);

  typedef struct packed {
    logic [W-1:0] evt;
    logic [W-1:0] prev;
  } ssr_grp_st_t;

  ssr_grp_st_t st_reg;
  ssr_grp_st_t st_next;

  if (W < 1 || W > 8) begin : g_bad_width
    $error("ssr_event_group: W must lie in 1..8");
  end

  // clear drops stored bits but a source still present re-sets them;
  // prev is zeroed too so a persisting source raises a fresh rise
  always_comb
  begin
    st_next = st_reg;
    if (clear_i)
    begin
      st_next.evt  = set_i;
      st_next.prev = '0;
    end
    else
    begin
      st_next.evt  = st_reg.evt | set_i;
      st_next.prev = st_reg.evt;
    end
  end

  // register stage
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign event_o   = st_reg.evt;
  assign summary_o = |(st_reg.evt & enable_i);
  assign rise_o    = |(st_reg.evt & ~st_reg.prev & enable_i);

endmodule : ssr_event_group

`default_nettype wire

// *** src/ssr_srq_latch.sv ***
// service request latch fed by enabled new events
`timescale 1ns/10ps
`default_nettype none

module ssr_srq_latch (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // new enabled events per summary position, enable mask, clear
  input  wire logic [7:0] rise_i,
  input  wire logic [7:0] sre_i,
  input  wire logic       clear_i,
  // latched request
  output logic            rqs_o
);

  ssr_pkg::ssr_srq_st_t st_reg;
  ssr_pkg::ssr_srq_st_t st_next;
  logic                 set_w;

  // the request position itself never triggers a request
  assign set_w = |(rise_i & sre_i & ssr_pkg::SRE_VALID_MASK);

  // set beats clear so a request in the clearing cycle survives
  always_comb
  begin
    st_next     = st_reg;
    st_next.rqs = set_w | (st_reg.rqs & ~clear_i);
  end

  // register stage
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rqs_o = st_reg.rqs;

endmodule : ssr_srq_latch

`default_nettype wire

// *** src/ssr_status_top.sv ***
// status summary byte, standard-event enable and service request logic
//
// Functional notes
// - summary bit 0 follows the busy processing flag.
// - summary bit 2 is set while error messages wait in the queue.
// - summary bit 3 carries the questionable group summary.
// - summary bit 4 is set while output message is available.
// - summary bit 5 carries the standard-event group summary.
// - a service request latches into summary bit 6 until cleared.
// - host services the request; device then clears the latched bit.
// - summary bit 7 carries the operation group summary.
// - group events reach their summary bit only when enabled.
// - a 0-to-1 event bit change raises a request; steady bits do not.
// - reading a group event register returns it, then clears it.
// - a persisting condition raises the request again after its event register is read.
// - clear-status zeroes standard, operation and questionable event registers.
// - clear-status zeroes summary byte, empties error and output queues.
// - clear-status zeroes the service-request enable mask.
// - host writes enable mask 0 to 255; each 1 enables its event.
// - standard summary is OR of enabled standard-event bits.
// - clear-status keeps enable mask; power-on clears it only when set.
// - enable mask query returns its weighted value, 0 to 189.
// - mask layout: bits 7,5,4,3,2,0 live; bits 6 and 1 zero.
// - set standard-event bits hold until read or clear-status.
`timescale 1ns/10ps
`default_nettype none

module ssr_status_top #(
  parameter int QW = 8,
  parameter int OW = 8
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // host command port
  input  wire logic                 cmd_valid_i,
  input  wire ssr_pkg::ssr_cmd_t    cmd_code_i,
  input  wire logic [7:0]           cmd_data_i,
  // power-on clear setting and retained enable values
  input  wire logic                 psc_i,
  input  wire logic [7:0]           std_en_saved_i,
  input  wire logic [7:0]           sre_saved_i,
  // device status sources
  input  wire logic                 processing_flag_i,
  input  wire logic                 error_queue_pending_i,
  input  wire logic                 msg_avail_i,
  input  wire logic [7:0]           std_event_i,
  input  wire logic [QW-1:0]        ques_cond_i,
  input  wire logic [QW-1:0]        ques_enable_i,
  input  wire logic [OW-1:0]        oper_cond_i,
  input  wire logic [OW-1:0]        operation_summary_enable_i,
  // register views
  output logic      [7:0]           status_byte_o,
  output logic      [7:0]           std_en_o,
  output logic      [7:0]           sre_o,
  // query answer
  output logic      [7:0]           rd_data_o,
  output logic                      rd_valid_o,
  // request and queue control
  output logic                      srq_o,
  output logic                      err_queue_clear_o,
  output logic                      out_queue_clear_o
);

  ssr_pkg::ssr_main_st_t st_reg;
  ssr_pkg::ssr_main_st_t st_next;

  // decoded command strobes
  logic       cls_w;
  logic       esr_rd_w;
  logic       qes_rd_w;
  logic       oes_rd_w;
  logic       sum_rd_w;

  // group results
  logic [7:0]    std_event_w;
  logic [QW-1:0] ques_event_w;
  logic [OW-1:0] oper_event_w;
  logic          std_sum_w;
  logic          ques_sum_w;
  logic          operation_summary_w;
  logic          std_rise_w;
  logic          ques_rise_w;
  logic          oper_rise_w;
  logic [7:0]    rise_vec_w;
  logic [7:0]    std_set_w;
  logic          rqs_w;

  if (QW < 1 || QW > 8 || OW < 1 || OW > 8) begin : g_bad_width
    $error("ssr_status_top: QW and OW must lie in 1..8");
  end

  // true for commands that place an answer on rd_data_o
  function automatic logic is_query(input ssr_pkg::ssr_cmd_t c);
    case (c)
      ssr_pkg::CMD_SUM_Q,
      ssr_pkg::CMD_STD_EN_Q,
      ssr_pkg::CMD_ESR_Q,
      ssr_pkg::CMD_SRE_Q,
      ssr_pkg::CMD_QES_Q,
      ssr_pkg::CMD_OES_Q: is_query = 1'b1;
      default:            is_query = 1'b0;
    endcase
  endfunction : is_query

  // one strobe per command; only valid cycles count
  function automatic logic cmd_is(input logic v,
                                  input ssr_pkg::ssr_cmd_t c,
                                  input ssr_pkg::ssr_cmd_t want);
    cmd_is = v && (c == want);
  endfunction : cmd_is

  assign cls_w    = cmd_is(cmd_valid_i, cmd_code_i, ssr_pkg::CMD_CLS);
  assign esr_rd_w = cmd_is(cmd_valid_i, cmd_code_i, ssr_pkg::CMD_ESR_Q);
  assign qes_rd_w = cmd_is(cmd_valid_i, cmd_code_i, ssr_pkg::CMD_QES_Q);
  assign oes_rd_w = cmd_is(cmd_valid_i, cmd_code_i, ssr_pkg::CMD_OES_Q);
  assign sum_rd_w = cmd_is(cmd_valid_i, cmd_code_i, ssr_pkg::CMD_SUM_Q);

  // standard events, plus the power-on event in the first cycle after reset;
  // dead positions are masked so they can never latch
  assign std_set_w = (std_event_i
                     | (st_reg.pon_pend ? ssr_pkg::STD_PON_EVENT : 8'h00))
                     & ssr_pkg::STD_VALID_MASK;

  // standard-event group: summary is OR of enabled latched bits
  ssr_event_group #(
    .W         (8)
  ) u_std_grp (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .set_i     (std_set_w),
    .enable_i  (st_reg.std_en),
    .clear_i   (esr_rd_w | cls_w),
    .event_o   (std_event_w),
    .summary_o (std_sum_w),
    .rise_o    (std_rise_w)
  );

  // questionable-condition group
  ssr_event_group #(
    .W         (QW)
  ) u_ques_grp (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .set_i     (ques_cond_i),
    .enable_i  (ques_enable_i),
    .clear_i   (qes_rd_w | cls_w),
    .event_o   (ques_event_w),
    .summary_o (ques_sum_w),
    .rise_o    (ques_rise_w)
  );

  // operation-condition group
  ssr_event_group #(
    .W         (OW)
  ) u_oper_grp (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .set_i     (oper_cond_i),
    .enable_i  (operation_summary_enable_i),
    .clear_i   (oes_rd_w | cls_w),
    .event_o   (oper_event_w),
    .summary_o (operation_summary_w),
    .rise_o    (oper_rise_w)
  );

  // new enabled events placed at their summary positions
  always_comb
  begin
    rise_vec_w                       = 8'h00;
    rise_vec_w[ssr_pkg::SUM_QUES_BIT] = ques_rise_w;
    rise_vec_w[ssr_pkg::SUM_ESB_BIT]  = std_rise_w;
    rise_vec_w[ssr_pkg::SUM_OPER_BIT] = oper_rise_w;
  end

  // service request latch; a summary-byte query counts as servicing it
  ssr_srq_latch u_srq (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .rise_i    (rise_vec_w),
    .sre_i     (st_reg.sre),
    .clear_i   (sum_rd_w | cls_w),
    .rqs_o     (rqs_w)
  );

  // next state of the register file, summary byte and answer path
  always_comb
  begin
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.err_clr  = 1'b0;
    st_next.out_clr  = 1'b0;
    st_next.pon_pend = 1'b0;

    // retained enables come back unless power-on clear is active
    if (st_reg.pon_pend && !psc_i)
    begin
      st_next.std_en = std_en_saved_i & ssr_pkg::STD_VALID_MASK;
      st_next.sre = sre_saved_i & ssr_pkg::SRE_VALID_MASK;
    end

    // summary byte rebuilt every cycle; bit 1 stays zero
    st_next.sum                        = 8'h00;
    st_next.sum[ssr_pkg::SUM_BUSY_BIT] = processing_flag_i;
    st_next.sum[ssr_pkg::SUM_ERR_BIT]  = error_queue_pending_i;
    st_next.sum[ssr_pkg::SUM_QUES_BIT] = ques_sum_w;
    st_next.sum[ssr_pkg::SUM_MAV_BIT]  = msg_avail_i;
    st_next.sum[ssr_pkg::SUM_ESB_BIT]  = std_sum_w;
    st_next.sum[ssr_pkg::SUM_RQS_BIT]  = rqs_w;
    st_next.sum[ssr_pkg::SUM_OPER_BIT] = operation_summary_w;

    if (cmd_valid_i)
    begin
      st_next.rd_valid = is_query(cmd_code_i);
      case (cmd_code_i)
        ssr_pkg::CMD_CLS:
        begin
          // enable mask for standard events survives on purpose
          st_next.sum     = ssr_pkg::SUM_RESET;
          st_next.err_clr = 1'b1;
          st_next.out_clr = 1'b1;
          st_next.sre     = ssr_pkg::SRE_RESET;
        end
        ssr_pkg::CMD_SUM_Q:
          st_next.rd_data = st_reg.sum;
        ssr_pkg::CMD_STD_EN_W:
          st_next.std_en = cmd_data_i & ssr_pkg::STD_VALID_MASK;
        ssr_pkg::CMD_STD_EN_Q:
          st_next.rd_data = st_reg.std_en;
        ssr_pkg::CMD_ESR_Q:
          st_next.rd_data = std_event_w;
        ssr_pkg::CMD_SRE_W:
          st_next.sre = cmd_data_i & ssr_pkg::SRE_VALID_MASK;
        ssr_pkg::CMD_SRE_Q:
          st_next.rd_data = st_reg.sre;
        ssr_pkg::CMD_QES_Q:
          st_next.rd_data = 8'(ques_event_w);
        ssr_pkg::CMD_OES_Q:
          st_next.rd_data = 8'(oper_event_w);
        default:
          st_next.rd_valid = 1'b0;
      endcase
    end
  end

  // register stage; power-on pending starts set so the first cycle
  // after release raises the power-on event and restores enables
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg          <= '0;
      st_reg.std_en   <= ssr_pkg::STD_EN_RESET;
      st_reg.sre      <= ssr_pkg::SRE_RESET;
      st_reg.sum      <= ssr_pkg::SUM_RESET;
      st_reg.rd_data  <= ssr_pkg::RD_RESET;
      st_reg.pon_pend <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from flops
  assign status_byte_o     = st_reg.sum;
  assign std_en_o          = st_reg.std_en;
  assign sre_o             = st_reg.sre;
  assign rd_data_o         = st_reg.rd_data;
  assign rd_valid_o        = st_reg.rd_valid;
  assign srq_o             = rqs_w;
  assign err_queue_clear_o = st_reg.err_clr;
  assign out_queue_clear_o = st_reg.out_clr;

endmodule : ssr_status_top

`default_nettype wire

// *** bench/ssr_status_monitor.sv ***
// port checker for the status summary and service request block
`timescale 1ns/10ps
`default_nettype none

module ssr_status_monitor #(
  parameter int QW = 8,
  parameter int OW = 8
) (
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  // command port and sources
  input wire logic              cmd_valid_i,
  input wire ssr_pkg::ssr_cmd_t cmd_code_i,
  input wire logic [7:0]        cmd_data_i,
  input wire logic              processing_flag_i,
  input wire logic              error_queue_pending_i,
  input wire logic [7:0]        std_event_i,
  // observed outputs
  input wire logic [7:0]        status_byte_o,
  input wire logic [7:0]        std_en_o,
  input wire logic [7:0]        sre_o,
  input wire logic [7:0]        rd_data_o,
  input wire logic              rd_valid_o,
  input wire logic              srq_o,
  input wire logic              err_queue_clear_o,
  input wire logic              out_queue_clear_o
);
  logic cls;
  logic hit;
  // clear-status zeroes the byte, so level checks step over it
  assign cls = cmd_valid_i && cmd_code_i == ssr_pkg::CMD_CLS;
  assign hit = |(std_event_i & std_en_o & ssr_pkg::STD_VALID_MASK);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // one cycle lag from a level source to its summary bit
  property p_lvl(logic src, int b);
    !cls |=> status_byte_o[b] == $past(src);
  endproperty
  // an enabled event with no host command that could clear it
  sequence s_fresh;
    hit && !cmd_valid_i ##1 !cmd_valid_i;
  endsequence
  sequence s_held;
    !cmd_valid_i ##1 status_byte_o[5] && !cmd_valid_i;
  endsequence

  a_busy_level: assert property (p_lvl(processing_flag_i, 0))
    else $error("busy bit wrong");
  a_error_level: assert property (p_lvl(error_queue_pending_i, 2))
    else $error("error bit wrong");
  a_unused_zero: assert property (status_byte_o[1] == 1'b0)
    else $error("bit 1 not zero");
  a_std_summary_set: assert property (s_fresh |=> status_byte_o[5])
    else $error("standard summary missed");
  a_std_event_held: assert property (s_held |=> status_byte_o[5])
    else $error("standard summary dropped");
  a_request_to_byte: assert property (!cls |=> status_byte_o[6] == $past(srq_o))
    else $error("request bit wrong");
  a_request_held: assert property (srq_o && !cls &&
    !(cmd_valid_i && cmd_code_i == ssr_pkg::CMD_SUM_Q) |=> srq_o)
    else $error("request lost");
  a_clear_status: assert property (cls |=> status_byte_o == 8'h00 &&
    sre_o == 8'h00 && err_queue_clear_o && out_queue_clear_o)
    else $error("clear-status incomplete");
  a_clear_keeps_mask: assert property (cls |=> std_en_o == $past(std_en_o))
    else $error("mask changed by clear");
  a_mask_write: assert property (cmd_valid_i &&
    cmd_code_i == ssr_pkg::CMD_STD_EN_W |=> std_en_o == ($past(cmd_data_i) & 8'hBD))
    else $error("mask write wrong");
  a_mask_query: assert property (cmd_valid_i &&
    cmd_code_i == ssr_pkg::CMD_STD_EN_Q |=> rd_valid_o && rd_data_o == $past(std_en_o))
    else $error("mask query wrong");
endmodule : ssr_status_monitor

bind ssr_status_top ssr_status_monitor #(.QW(QW), .OW(OW)) ssr_status_monitor_i (
  .sys_clk_i, .rst_n_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i,
  .processing_flag_i, .error_queue_pending_i, .std_event_i, .status_byte_o,
  .std_en_o, .sre_o, .rd_data_o, .rd_valid_o, .srq_o, .err_queue_clear_o,
  .out_queue_clear_o
);

`default_nettype wire

// *** bench/ssr_host_model.sv ***
// remote host model driving the command port and taking answers
`timescale 1ns/10ps
`default_nettype none

module ssr_host_model (
  // clock and answer
  input  wire logic         sys_clk_i,
  input  wire logic         rd_valid_i,
  input  wire logic [7:0]   rd_data_i,
  // command strobe
  output ssr_pkg::ssr_cmd_t cmd_code_o,
  output logic              cmd_valid_o,
  output logic [7:0]        cmd_data_o
);
  logic [7:0] ans;
  logic       ans_ok;

  // idle port at time zero
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = ssr_pkg::CMD_NOP;
    cmd_data_o  = 8'h00;
  end

  // one command a call, any 8-bit value; released data shows its inverse
  task automatic send(input ssr_pkg::ssr_cmd_t c, input logic [7:0] d);
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= c;
    cmd_data_o  <= d;
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o  <= ssr_pkg::CMD_NOP;
    cmd_data_o  <= ~d;
    #1;
    ans_ok = rd_valid_i;
    ans    = rd_data_i;
  endtask : send
endmodule : ssr_host_model

`default_nettype wire

// *** bench/ssr_status_top_bench.sv ***
// self-checking bench for the status summary and service request block
`timescale 1ns/10ps
`default_nettype none

module ssr_status_top_bench;
  logic              sys_clk_i, rst_n_i, cmd_valid_i, psc_i;
  ssr_pkg::ssr_cmd_t cmd_code_i;
  logic [7:0]        cmd_data_i, std_en_saved_i, sre_saved_i, std_event_i;
  logic              processing_flag_i, error_queue_pending_i, msg_avail_i;
  logic [7:0]        ques_cond_i, ques_enable_i, oper_cond_i;
  logic [7:0]        operation_summary_enable_i, status_byte_o, std_en_o, sre_o;
  logic [7:0]        rd_data_o;
  logic              rd_valid_o, srq_o, err_queue_clear_o, out_queue_clear_o;
  int                mismatches, comparisons, cycles;

  ssr_status_top ssr_status_top_i (
    .sys_clk_i, .rst_n_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i, .psc_i,
    .std_en_saved_i, .sre_saved_i, .processing_flag_i, .error_queue_pending_i,
    .msg_avail_i, .std_event_i, .ques_cond_i, .ques_enable_i, .oper_cond_i,
    .operation_summary_enable_i, .status_byte_o, .std_en_o, .sre_o, .rd_data_o,
    .rd_valid_o, .srq_o, .err_queue_clear_o, .out_queue_clear_o
  );
  ssr_host_model host_i (
    .sys_clk_i, .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .cmd_code_o(cmd_code_i), .cmd_valid_o(cmd_valid_i), .cmd_data_o(cmd_data_i)
  );

  // 100 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // compare, wait, query helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wt
  task automatic q(input ssr_pkg::ssr_cmd_t c, input logic [7:0] exp);
    host_i.send(c, 8'h00);
    chk({7'h00, host_i.ans_ok}, 8'h01);
    chk(host_i.ans, exp);
  endtask : q

  task automatic t_power_on;
    chk(std_en_o, 8'h00);
    q(ssr_pkg::CMD_ESR_Q, 8'h80);
    q(ssr_pkg::CMD_ESR_Q, 8'h00);
  endtask : t_power_on

  // undefined bits 6 and 1 are dropped on write
  task automatic t_mask;
    logic [7:0] wr [3] = '{8'hFF, 8'h42, 8'h81};
    logic [7:0] rd [3] = '{8'hBD, 8'h00, 8'h81};
    for (int i = 0; i < 3; i++)
    begin
      host_i.send(ssr_pkg::CMD_STD_EN_W, wr[i]);
      q(ssr_pkg::CMD_STD_EN_Q, rd[i]);
    end
  endtask : t_mask

  task automatic t_levels;
    @(posedge sys_clk_i);
    processing_flag_i     <= 1'b1;
    error_queue_pending_i <= 1'b1;
    msg_avail_i           <= 1'b1;
    wt(2);
    chk(status_byte_o & 8'h17, 8'h15);
  endtask : t_levels

  // a held event must not re-request until its register is read
  task automatic t_request;
    host_i.send(ssr_pkg::CMD_STD_EN_W, 8'h10);
    host_i.send(ssr_pkg::CMD_SRE_W, 8'h20);
    @(posedge sys_clk_i);
    std_event_i <= 8'h10;
    wt(4);
    chk(status_byte_o & 8'h60, 8'h60);
    q(ssr_pkg::CMD_SUM_Q, 8'h75);
    wt(4);
    chk({7'h00, srq_o}, 8'h00);
    q(ssr_pkg::CMD_ESR_Q, 8'h10);
    wt(4);
    chk({7'h00, srq_o}, 8'h01);
    host_i.send(ssr_pkg::CMD_SRE_W, 8'h00);
    host_i.send(ssr_pkg::CMD_SUM_Q, 8'h00);
    q(ssr_pkg::CMD_ESR_Q, 8'h10);
    wt(4);
    chk({7'h00, srq_o}, 8'h00);
    host_i.send(ssr_pkg::CMD_STD_EN_W, 8'h00);
    host_i.send(ssr_pkg::CMD_SRE_W, 8'h20);
    @(posedge sys_clk_i);
    std_event_i <= 8'h00;
    q(ssr_pkg::CMD_ESR_Q, 8'h10);
    @(posedge sys_clk_i);
    std_event_i <= 8'h10;
    @(posedge sys_clk_i);
    std_event_i <= 8'h00;
    wt(4);
    chk({status_byte_o[7:5], srq_o}, 8'h00);
  endtask : t_request

  task automatic t_groups;
    @(posedge sys_clk_i);
    ques_cond_i <= 8'h04;
    oper_cond_i <= 8'h01;
    wt(4);
    chk(status_byte_o & 8'h88, 8'h00);
    @(posedge sys_clk_i);
    ques_enable_i              <= 8'h04;
    operation_summary_enable_i <= 8'h01;
    wt(4);
    chk(status_byte_o & 8'h88, 8'h88);
    @(posedge sys_clk_i);
    ques_cond_i <= 8'h00;
    oper_cond_i <= 8'h00;
    q(ssr_pkg::CMD_QES_Q, 8'h04);
    q(ssr_pkg::CMD_OES_Q, 8'h01);
    wt(3);
    chk(status_byte_o & 8'h88, 8'h00);
  endtask : t_groups

  task automatic t_clear;
    @(posedge sys_clk_i);
    ques_cond_i <= 8'h04;
    oper_cond_i <= 8'h01;
    @(posedge sys_clk_i);
    ques_cond_i <= 8'h00;
    oper_cond_i <= 8'h00;
    wt(3);
    host_i.send(ssr_pkg::CMD_CLS, 8'h00);
    chk(status_byte_o, 8'h00);
    chk({6'h00, err_queue_clear_o, out_queue_clear_o}, 8'h03);
    q(ssr_pkg::CMD_ESR_Q, 8'h00);
    q(ssr_pkg::CMD_QES_Q, 8'h00);
    q(ssr_pkg::CMD_OES_Q, 8'h00);
  endtask : t_clear

  // second reset with retained masks restored
  task automatic t_restore;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    psc_i   <= 1'b0;
    wt(3);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wt(2);
    chk(std_en_o, 8'hBD);
    chk(sre_o, 8'hBF);
    q(ssr_pkg::CMD_SRE_Q, 8'hBF);
    host_i.send(ssr_pkg::CMD_CLS, 8'h00);
    chk(std_en_o, 8'hBD);
    chk(sre_o, 8'h00);
    q(ssr_pkg::CMD_SRE_Q, 8'h00);
    q(ssr_pkg::CMD_STD_EN_Q, 8'hBD);
  endtask : t_restore

  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // hang guard, far above the hundred-odd cycles the run needs
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    {mismatches, comparisons, cycles} = '0;
    {rst_n_i, processing_flag_i, error_queue_pending_i, msg_avail_i} = '0;
    psc_i = 1'b1;
    {std_en_saved_i, sre_saved_i} = 16'hFFFF;
    {std_event_i, ques_cond_i, ques_enable_i} = '0;
    {oper_cond_i, operation_summary_enable_i} = '0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wt(2);
    t_power_on();
    t_mask();
    t_levels();
    t_request();
    t_groups();
    t_clear();
    t_restore();
    close_out();
  end
endmodule : ssr_status_top_bench

`default_nettype wire
